/* rtl/fas_pkg.sv */
// Purpose: constants and types of the flash algorithm sequencer host
// Assumes: 250 MHz mclk_i, 16-bit flash word bus
// Notes: times in ns, cycle counts rounded up
package fas_pkg;
    localparam int CLK_NS = 4;
    localparam int AW = 26;
    localparam int DW = 16;
    localparam int PAGE_LSB = 4;
    localparam int T_ACC_NS = 100;
    localparam int T_PACC_NS = 25;
    localparam int T_WP_NS = 35;
    localparam int T_WPH_NS = 20;
    localparam int T_RP_NS = 200;
    localparam int T_RPH_NS = 35000;
    localparam int T_PRS_NS = 40000;
    localparam int T_BUSY_NS = 100;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int PACC_CYC = (T_PACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RPH_CYC = (T_RPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int PRS_CYC = (T_PRS_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC = 2;
    localparam logic [AW-1:0] UNLOCK1_ADDR = 26'h0000555;
    localparam logic [AW-1:0] UNLOCK2_ADDR = 26'h00002AA;
    localparam logic [DW-1:0] UNLOCK1_DATA = 16'h00AA;
    localparam logic [DW-1:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [DW-1:0] PROG_SETUP_DATA = 16'h00A0;
    localparam logic [DW-1:0] SUSPEND_DATA = 16'h00B0;
    localparam logic [DW-1:0] RESUME_DATA = 16'h0030;
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROG = 3'h1,
        OP_PROG_OVL = 3'h2,
        OP_SUSPEND = 3'h3,
        OP_RESUME = 3'h4,
        OP_RESET = 3'h5,
        OP_WRITE = 3'h6
    } fas_op_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_READ = 3'h1,
        ST_WR_LOW = 3'h2,
        ST_WR_HIGH = 3'h3,
        ST_RST_LOW = 3'h4,
        ST_RST_REC = 3'h5
    } fas_state_type;
endpackage

/* rtl/fas_host.sv */
// Purpose: host-side sequencer driving a parallel NOR flash over its pins
// Assumes: commands arrive on a valid/ready port in the mclk_i domain
// Notes: one command at a time; answer is a one-cycle rsp_valid_o
`timescale 1ns/10ps
// How it works
// - the page is address bits above 3; bits 3..0 pick the word.
// - a suspend waits for the resume-to-suspend interval to pass.
// - reset pulse aborts everything; host waits recovery then may reissue.
// - word program is two unlocks, setup, then address and data.
// - overlay program skips both unlock writes.
// - unlocks are AA at word 555, then 55 at word 2AA.
module fas_host #(
    parameter bit EXT_TEMP = 1'b0,
    parameter int RPH_CYCLES = fas_pkg::RPH_CYC,
    parameter int PRS_CYCLES = fas_pkg::PRS_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire fas_pkg::fas_op_type cmd_op_i,
    input wire logic [fas_pkg::AW-1:0] cmd_addr_i,
    input wire logic [fas_pkg::DW-1:0] cmd_data_i,
    output logic rsp_valid_o,
    output logic rsp_err_o,
    output logic [fas_pkg::DW-1:0] rsp_data_o,
    output logic busy_o,
    output logic suspended_o,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    output logic flash_reset_n_o,
    output logic [fas_pkg::AW-1:0] flash_addr_o,
    output logic [fas_pkg::DW-1:0] data_bus_o,
    output logic data_bus_oe_o,
    input wire logic [fas_pkg::DW-1:0] data_bus_i,
    input wire logic ready_busy_n_i
);
    if (RPH_CYCLES < 1 || RPH_CYCLES > 65535 || PRS_CYCLES < 1 || PRS_CYCLES > 65535) begin : g_chk
        $error("fas_host: cycle parameter out of 16-bit range");
    end

    localparam int PAGE_LSB_W = fas_pkg::PAGE_LSB;
    fas_pkg::fas_state_type state_q, state_d;
    fas_pkg::fas_op_type op_q, op_d;
    logic [15:0] cnt_q, cnt_d, settle_q, settle_d, rs_cnt_q, rs_cnt_d;
    logic [1:0] step_q, step_d;
    logic [fas_pkg::AW-1:0] addr_q, addr_d, pin_addr_q, pin_addr_d;
    logic [fas_pkg::DW-1:0] wdata_q, wdata_d, pin_data_q, pin_data_d, rdata_q, rdata_d;
    logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, rst_n_q, rst_n_d, doe_q, doe_d;
    logic [fas_pkg::AW-1:PAGE_LSB_W] page_q, page_d;
    logic page_valid_q, page_valid_d, busy_q, busy_d, psusp_q, psusp_d;
    logic rsp_q, rsp_d, err_q, err_d, rd_hit_q, rd_hit_d;
    logic rb_s1_q, rb_s2_q;
    logic [fas_pkg::DW-1:0] db_s1_q, db_s2_q;
    logic start, refuse, hit;

    // Address and data of write number step for an operation
    function automatic logic [fas_pkg::AW+fas_pkg::DW-1:0] seq_word(
        input fas_pkg::fas_op_type op, input logic [1:0] step,
        input logic [fas_pkg::AW-1:0] a, input logic [fas_pkg::DW-1:0] d);
        logic [1:0] s;
        s = (op == fas_pkg::OP_PROG) ? step : step + 2'h2;
        if (op == fas_pkg::OP_SUSPEND) begin
            seq_word = {a, fas_pkg::SUSPEND_DATA};
        end else if (op == fas_pkg::OP_RESUME) begin
            seq_word = {a, fas_pkg::RESUME_DATA};
        end else if (op == fas_pkg::OP_WRITE || s == 2'h3) begin
            seq_word = {a, d};
        end else if (s == 2'h0) begin
            seq_word = {fas_pkg::UNLOCK1_ADDR, fas_pkg::UNLOCK1_DATA};
        end else if (s == 2'h1) begin
            seq_word = {fas_pkg::UNLOCK2_ADDR, fas_pkg::UNLOCK2_DATA};
        end else begin
            seq_word = {fas_pkg::UNLOCK1_ADDR, fas_pkg::PROG_SETUP_DATA};
        end
    endfunction

    function automatic logic [1:0] last_step(input fas_pkg::fas_op_type op);
        last_step = (op == fas_pkg::OP_PROG) ? 2'h3 :
            (op == fas_pkg::OP_PROG_OVL) ? 2'h1 : 2'h0;
    endfunction

    assign hit = page_valid_q && page_q == cmd_addr_i[fas_pkg::AW-1:PAGE_LSB_W];
    assign cmd_ready_o = state_q == fas_pkg::ST_IDLE
        && !(cmd_op_i == fas_pkg::OP_SUSPEND && rs_cnt_q != 16'h0000);
    assign start = cmd_valid_i && cmd_ready_o;
    always_comb begin
        refuse = 1'b0;
        if (busy_q && cmd_op_i != fas_pkg::OP_SUSPEND && cmd_op_i != fas_pkg::OP_READ
            && cmd_op_i != fas_pkg::OP_RESET) begin
            refuse = 1'b1;
        end
        if (psusp_q && (cmd_op_i == fas_pkg::OP_PROG || cmd_op_i == fas_pkg::OP_PROG_OVL)) begin
            refuse = 1'b1;
        end
        if (cmd_op_i == fas_pkg::OP_SUSPEND && !busy_q) begin
            refuse = 1'b1;
        end
        if (cmd_op_i == fas_pkg::OP_RESUME && !psusp_q) begin
            refuse = 1'b1;
        end
        if (EXT_TEMP && cmd_op_i == fas_pkg::OP_PROG) begin
            refuse = 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        cnt_d = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
        settle_d = (settle_q != 16'h0000) ? settle_q - 16'h0001 : settle_q;
        rs_cnt_d = (rs_cnt_q != 16'h0000) ? rs_cnt_q - 16'h0001 : rs_cnt_q;
        step_d = step_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        pin_addr_d = pin_addr_q;
        pin_data_d = pin_data_q;
        rdata_d = rdata_q;
        ce_n_d = ce_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        rst_n_d = rst_n_q;
        doe_d = doe_q;
        page_d = page_q;
        page_valid_d = page_valid_q && !ce_n_q;
        busy_d = busy_q;
        psusp_d = psusp_q;
        rsp_d = 1'b0;
        err_d = 1'b0;
        rd_hit_d = rd_hit_q;
        // Busy ends once ready_busy_n has had time to fall and is high again
        if (busy_q && settle_q == 16'h0000 && rb_s2_q) begin
            busy_d = 1'b0;
        end
        case (state_q)
            fas_pkg::ST_IDLE: begin
                if (start && refuse) begin
                    rsp_d = 1'b1;
                    err_d = 1'b1;
                end else if (start) begin
                    op_d = cmd_op_i;
                    addr_d = cmd_addr_i;
                    wdata_d = cmd_data_i;
                    step_d = 2'h0;
                    if (cmd_op_i == fas_pkg::OP_READ) begin
                        state_d = fas_pkg::ST_READ;
                        ce_n_d = 1'b0;
                        oe_n_d = 1'b0;
                        pin_addr_d = cmd_addr_i;
                        rd_hit_d = hit;
                        // Spare cycle: data may only just settle at the access time
                        cnt_d = hit ? 16'(fas_pkg::PACC_CYC + fas_pkg::SYNC_CYC + 1)
                            : 16'(fas_pkg::ACC_CYC + fas_pkg::SYNC_CYC + 1);
                    end else if (cmd_op_i == fas_pkg::OP_RESET) begin
                        state_d = fas_pkg::ST_RST_LOW;
                        ce_n_d = 1'b1;
                        oe_n_d = 1'b1;
                        rst_n_d = 1'b0;
                        cnt_d = 16'(fas_pkg::RP_CYC);
                    end else begin
                        state_d = fas_pkg::ST_WR_LOW;
                        {pin_addr_d, pin_data_d} = seq_word(cmd_op_i, 2'h0, cmd_addr_i, cmd_data_i);
                        ce_n_d = 1'b0;
                        oe_n_d = 1'b1;
                        we_n_d = 1'b0;
                        doe_d = 1'b1;
                        cnt_d = 16'(fas_pkg::WP_CYC);
                    end
                end
            end
            fas_pkg::ST_READ: begin
                if (cnt_q == 16'h0000) begin
                    rdata_d = db_s2_q;
                    rsp_d = 1'b1;
                    page_d = addr_q[fas_pkg::AW-1:PAGE_LSB_W];
                    page_valid_d = 1'b1;
                    state_d = fas_pkg::ST_IDLE;
                end
            end
            fas_pkg::ST_WR_LOW: begin
                if (cnt_q == 16'h0000) begin
                    we_n_d = 1'b1;
                    ce_n_d = 1'b1;
                    cnt_d = 16'(fas_pkg::WPH_CYC);
                    state_d = fas_pkg::ST_WR_HIGH;
                end
            end
            fas_pkg::ST_WR_HIGH: begin
                if (cnt_q == 16'h0000) begin
                    doe_d = 1'b0;
                    if (step_q != last_step(op_q)) begin
                        step_d = step_q + 2'h1;
                        {pin_addr_d, pin_data_d} = seq_word(op_q, step_q + 2'h1, addr_q, wdata_q);
                        ce_n_d = 1'b0;
                        we_n_d = 1'b0;
                        doe_d = 1'b1;
                        cnt_d = 16'(fas_pkg::WP_CYC);
                        state_d = fas_pkg::ST_WR_LOW;
                    end else begin
                        rsp_d = 1'b1;
                        state_d = fas_pkg::ST_IDLE;
                        if (op_q != fas_pkg::OP_WRITE && op_q != fas_pkg::OP_SUSPEND) begin
                            busy_d = 1'b1;
                            settle_d = 16'(fas_pkg::BUSY_CYC + fas_pkg::SYNC_CYC);
                        end
                        // Suspended algorithm no longer busy, so resume is accepted
                        if (op_q == fas_pkg::OP_SUSPEND) begin
                            psusp_d = 1'b1;
                            busy_d = 1'b0;
                        end
                        if (op_q == fas_pkg::OP_RESUME) begin
                            psusp_d = 1'b0;
                            rs_cnt_d = 16'(PRS_CYCLES);
                        end
                    end
                end
            end
            fas_pkg::ST_RST_LOW: begin
                if (cnt_q == 16'h0000) begin
                    rst_n_d = 1'b1;
                    cnt_d = 16'(RPH_CYCLES);
                    state_d = fas_pkg::ST_RST_REC;
                end
            end
            fas_pkg::ST_RST_REC: begin
                busy_d = 1'b0;
                psusp_d = 1'b0;
                rs_cnt_d = 16'h0000;
                page_valid_d = 1'b0;
                if (cnt_q == 16'h0000) begin
                    rsp_d = 1'b1;
                    state_d = fas_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = fas_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= fas_pkg::ST_IDLE;
            op_q <= fas_pkg::OP_READ;
            cnt_q <= 16'h0000;
            settle_q <= 16'h0000;
            rs_cnt_q <= 16'h0000;
            step_q <= 2'h0;
            addr_q <= '0;
            wdata_q <= '0;
            pin_addr_q <= '0;
            pin_data_q <= '0;
            rdata_q <= '0;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            rst_n_q <= 1'b1;
            doe_q <= 1'b0;
            page_q <= '0;
            page_valid_q <= 1'b0;
            busy_q <= 1'b0;
            psusp_q <= 1'b0;
            rsp_q <= 1'b0;
            err_q <= 1'b0;
            rd_hit_q <= 1'b0;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
            db_s1_q <= '0;
            db_s2_q <= '0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            settle_q <= settle_d;
            rs_cnt_q <= rs_cnt_d;
            step_q <= step_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            pin_addr_q <= pin_addr_d;
            pin_data_q <= pin_data_d;
            rdata_q <= rdata_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            rst_n_q <= rst_n_d;
            doe_q <= doe_d;
            page_q <= page_d;
            page_valid_q <= page_valid_d;
            busy_q <= busy_d;
            psusp_q <= psusp_d;
            rsp_q <= rsp_d;
            err_q <= err_d;
            rd_hit_q <= rd_hit_d;
            rb_s1_q <= ready_busy_n_i;
            rb_s2_q <= rb_s1_q;
            db_s1_q <= data_bus_i;
            db_s2_q <= db_s1_q;
        end
    end

    assign rsp_valid_o = rsp_q;
    assign rsp_err_o = err_q;
    assign rsp_data_o = rdata_q;
    assign busy_o = busy_q;
    assign suspended_o = psusp_q;
    assign flash_ce_n_o = ce_n_q;
    assign flash_oe_n_o = oe_n_q;
    assign flash_we_n_o = we_n_q;
    assign flash_reset_n_o = rst_n_q;
    assign flash_addr_o = pin_addr_q;
    assign data_bus_o = pin_data_q;
    assign data_bus_oe_o = doe_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    a_unlock1_value: assert property (state_q == fas_pkg::ST_WR_LOW && op_q == fas_pkg::OP_PROG
        && step_q == 2'h0 |-> pin_addr_q == 26'h0000555 && pin_data_q == 16'h00AA)
        else $error("first unlock write wrong");
    a_unlock2_value: assert property (state_q == fas_pkg::ST_WR_LOW && op_q == fas_pkg::OP_PROG
        && step_q == 2'h1 |-> pin_addr_q == 26'h00002AA && pin_data_q == 16'h0055)
        else $error("second unlock write wrong");
    a_prog_data_last: assert property (state_q == fas_pkg::ST_WR_LOW && $rose(step_q == 2'h3)
        |-> op_q == fas_pkg::OP_PROG && pin_data_q == wdata_q && pin_addr_q == addr_q)
        else $error("program data not on fourth write");
    a_ovl_no_unlock: assert property (op_q == fas_pkg::OP_PROG_OVL && state_q == fas_pkg::ST_WR_LOW
        |-> pin_data_q != 16'h00AA || step_q == 2'h1)
        else $error("overlay program sent an unlock");
    a_busy_only_susp: assert property (start && busy_q && !rsp_d
        |-> cmd_op_i inside {fas_pkg::OP_SUSPEND, fas_pkg::OP_READ, fas_pkg::OP_RESET})
        else $error("command sent while program runs");
    a_psusp_no_prog: assert property (start && psusp_q
        && cmd_op_i inside {fas_pkg::OP_PROG, fas_pkg::OP_PROG_OVL} |=> rsp_q && err_q)
        else $error("program not refused in suspend");
    a_susp_spacing: assert property (start && cmd_op_i == fas_pkg::OP_SUSPEND |-> rs_cnt_q == 16'h0000)
        else $error("suspend too soon after resume");
    a_read_latency: assert property (start && cmd_op_i == fas_pkg::OP_READ && !hit
        |=> (state_q == fas_pkg::ST_READ && !ce_n_q)[*8])
        else $error("random read ended early");
    a_page_drop: assert property (ce_n_q |=> !page_valid_q)
        else $error("page kept after deselect");
    a_reset_clears: assert property ($rose(state_q == fas_pkg::ST_RST_REC)
        |=> !busy_q && !psusp_q && !page_valid_q && flash_reset_n_o)
        else $error("reset did not clear state");
    a_ext_no_word: assert property (EXT_TEMP && start && cmd_op_i == fas_pkg::OP_PROG
        |=> err_q) else $error("word program allowed on extended part");

    c_page_hit: cover property (start && cmd_op_i == fas_pkg::OP_READ && hit);
    c_prog_done: cover property (busy_q ##1 !busy_q);
    c_suspend: cover property ($rose(psusp_q));
    c_reset: cover property (state_q == fas_pkg::ST_RST_REC);
    c_hit_done: cover property (state_q == fas_pkg::ST_READ && rd_hit_q && cnt_q == 16'h0000);
endmodule

/* testbench/fas_flash_model.sv */
// Purpose: behavioural parallel NOR flash standing on the host pins
// Assumes: word addresses, one algorithm at a time, sectors of 256 words
// Notes: a released or unsettled bus shows the inverse of the last word
`timescale 1ns/10ps
module fas_flash_model #(
    parameter int ACC_NS = 100,
    parameter int PACC_NS = 25,
    parameter int ALG_NS = 2000,
    parameter logic [15:0] OVL_IN = 16'h0040,
    parameter logic [15:0] OVL_OUT = 16'h0090
) (
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic reset_n_i,
    input wire logic [25:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic dq_oe_i,
    output logic [15:0] dq_o,
    output logic ready_busy_n_o
);
    logic [15:0] mem [logic [26:0]];
    logic [15:0] last_q = 16'h0000;
    logic [21:0] page;
    logic page_ok = 1'b0;
    logic busy = 1'b0;
    logic susp = 1'b0;
    logic ovl = 1'b0;
    logic erase = 1'b0;
    logic [26:0] tgt;
    logic [15:0] tdat;
    realtime t_ok = 0;
    int step = 0;
    int left = 0;

    function automatic logic [15:0] rd(input logic [26:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction

    initial begin
        dq_o = 16'h0000;
        ready_busy_n_o = 1'b1;
    end

    // Whole page fetched on a miss; ce high drops it
    always @(ce_n_i or addr_i) begin
        if (ce_n_i) begin
            page_ok = 1'b0;
        end else begin
            t_ok = $realtime + ((page_ok && page == addr_i[25:4]) ? PACC_NS : ACC_NS);
            page = addr_i[25:4];
            page_ok = 1'b1;
        end
    end

    always #1 begin
        if (ce_n_i || oe_n_i || $realtime < t_ok) begin
            dq_o = ~last_q;
        end else begin
            dq_o = (busy && !susp) ? 16'h0000 : rd({ovl, addr_i});
            last_q = dq_o;
        end
        if (busy && !susp) begin
            left--;
            if (left == 0) begin
                busy = 1'b0;
                foreach (mem[k]) begin
                    if (erase && k[26:8] == tgt[26:8]) mem[k] = 16'hFFFF;
                end
                if (!erase) mem[tgt] = rd(tgt) & tdat;
            end
        end
        ready_busy_n_o = !(busy && !susp);
    end

    always @(negedge we_n_i) begin
        #1;
        if (!ce_n_i && dq_oe_i && reset_n_i) begin
            if (busy) begin
                if (dq_i == 16'h00B0) susp = 1'b1;
                if (dq_i == 16'h0030) susp = 1'b0;
            end else begin
                case (step)
                    0: begin
                        if (ovl && dq_i == OVL_OUT) ovl = 1'b0;
                        step = (ovl && dq_i == 16'h00A0) ? 3 : 0;
                        if (dq_i == 16'h00AA && addr_i == 26'h0000555) step = 1;
                    end
                    4: step = (dq_i == 16'h00AA && addr_i == 26'h0000555) ? 5 : 0;
                    1, 5: step = (dq_i == 16'h0055 && addr_i == 26'h00002AA) ? step + 1 : 0;
                    2: begin
                        if (dq_i == OVL_IN) ovl = 1'b1;
                        step = (dq_i == 16'h00A0) ? 3 : (dq_i == 16'h0080) ? 4 : 0;
                    end
                    default: begin
                        tgt = {ovl, addr_i};
                        tdat = dq_i;
                        erase = step == 6;
                        busy = step == 3 || dq_i == 16'h0030;
                        left = ALG_NS;
                        step = 0;
                    end
                endcase
            end
        end
    end

    always @(negedge reset_n_i) begin
        {busy, susp, ovl} = 3'h0;
        step = 0;
    end
endmodule

/* testbench/fas_host_tb_top.sv */
// Purpose: self-checking bench for the flash host sequencer
// Assumes: behavioural flash model on the pins
// Notes: short reset recovery and resume intervals
`timescale 1ns/10ps
module fas_host_tb_top;
    logic mclk_i, sys_rst_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, rsp_err_o, r_err;
    logic busy_o, suspended_o, ce_n, oe_n, we_n, rst_n, dq_oe, rb_n;
    fas_pkg::fas_op_type cmd_op_i;
    logic [25:0] cmd_addr_i, addr;
    logic [15:0] cmd_data_i, rsp_data_o, dq_out, dq_in, r_data;
    int mismatches = 0;
    int n_compared = 0;
    int r_lat, r_stall, lat_r;

    fas_host #(.RPH_CYCLES(20), .PRS_CYCLES(20)) u_fas_host (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
        .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
        .rsp_data_o(rsp_data_o), .busy_o(busy_o), .suspended_o(suspended_o),
        .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
        .flash_reset_n_o(rst_n), .flash_addr_o(addr), .data_bus_o(dq_out),
        .data_bus_oe_o(dq_oe), .data_bus_i(dq_in), .ready_busy_n_i(rb_n));

    fas_flash_model u_fas_flash_model (
        .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .reset_n_i(rst_n),
        .addr_i(addr), .dq_i(dq_out), .dq_oe_i(dq_oe), .dq_o(dq_in),
        .ready_busy_n_o(rb_n));

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmd(input fas_pkg::fas_op_type op, input logic [25:0] a,
            input logic [15:0] d);
        @(negedge mclk_i);
        cmd_valid_i = 1'b1;
        cmd_op_i = op;
        cmd_addr_i = a;
        cmd_data_i = d;
        r_stall = 0;
        // Ready depends on the op, so look once it has settled
        #1;
        while (cmd_ready_o !== 1'b1 && r_stall < 9000) begin
            @(negedge mclk_i);
            #1;
            r_stall++;
        end
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        r_lat = 1;
        while (rsp_valid_o !== 1'b1 && r_lat < 9000) begin
            @(negedge mclk_i);
            r_lat++;
        end
        r_err = rsp_err_o;
        r_data = rsp_data_o;
        check("rsp_valid_o", 16'h0001, 16'(rsp_valid_o));
    endtask

    task automatic op_chk(input fas_pkg::fas_op_type op, input logic [25:0] a,
            input logic [15:0] d, input logic e);
        cmd(op, a, d);
        check("rsp_err_o", 16'(e), 16'(r_err));
    endtask

    task automatic rd_chk(input logic [25:0] a, input logic [15:0] exp);
        cmd(fas_pkg::OP_READ, a, 16'h0000);
        check("rsp_data_o", exp, r_data);
    endtask

    task automatic wait_idle();
        int n = 0;
        while (busy_o !== 1'b0 && n < 9000) begin
            @(negedge mclk_i);
            n++;
        end
        check("busy_o", 16'h0000, 16'(busy_o));
    endtask

    task automatic s_program();
        op_chk(fas_pkg::OP_PROG, 26'h0000123, 16'h5A5A, 1'b0);
        @(negedge mclk_i);
        check("busy_o", 16'h0001, 16'(busy_o));
        wait_idle();
        rd_chk(26'h0000123, 16'h5A5A);
        op_chk(fas_pkg::OP_PROG, 26'h0000123, 16'h0FF0, 1'b0);
        wait_idle();
        rd_chk(26'h0000123, 16'h0A50);
    endtask

    task automatic s_page();
        rd_chk(26'h0000200, 16'hFFFF);
        lat_r = r_lat;
        rd_chk(26'h0000123, 16'h0A50);
        check("random latency", 16'(lat_r), 16'(r_lat));
        rd_chk(26'h000012F, 16'hFFFF);
        check("page gain", 16'(fas_pkg::ACC_CYC - fas_pkg::PACC_CYC), 16'(lat_r - r_lat));
        rd_chk(26'h0000133, 16'hFFFF);
        check("new page latency", 16'(lat_r), 16'(r_lat));
        op_chk(fas_pkg::OP_WRITE, 26'h0000000, 16'h00F0, 1'b0);
        rd_chk(26'h0000133, 16'hFFFF);
        check("reselect latency", 16'(lat_r), 16'(r_lat));
    endtask

    task automatic s_suspend();
        op_chk(fas_pkg::OP_PROG, 26'h0000300, 16'h1234, 1'b0);
        op_chk(fas_pkg::OP_PROG, 26'h0000301, 16'h0000, 1'b1);
        op_chk(fas_pkg::OP_RESUME, 26'h0000000, 16'h0000, 1'b1);
        op_chk(fas_pkg::OP_SUSPEND, 26'h0000300, 16'h0000, 1'b0);
        check("suspended_o", 16'h0001, 16'(suspended_o));
        rd_chk(26'h0000400, 16'hFFFF);
        op_chk(fas_pkg::OP_PROG, 26'h0000401, 16'h0000, 1'b1);
        op_chk(fas_pkg::OP_RESUME, 26'h0000000, 16'h0000, 1'b0);
        op_chk(fas_pkg::OP_SUSPEND, 26'h0000300, 16'h0000, 1'b0);
        check("suspend stall", 16'h0001, 16'(r_stall > 10));
        op_chk(fas_pkg::OP_RESUME, 26'h0000000, 16'h0000, 1'b0);
        wait_idle();
        rd_chk(26'h0000300, 16'h1234);
        op_chk(fas_pkg::OP_SUSPEND, 26'h0000300, 16'h0000, 1'b1);
    endtask

    task automatic s_erase();
        logic [25:0] ea [6] = '{26'h0000555, 26'h00002AA, 26'h0000555,
            26'h0000555, 26'h00002AA, 26'h0000120};
        logic [15:0] ed [6] = '{16'h00AA, 16'h0055, 16'h0080, 16'h00AA, 16'h0055, 16'h0030};
        int n = 0;
        foreach (ea[i]) op_chk(fas_pkg::OP_WRITE, ea[i], ed[i], 1'b0);
        while (rb_n !== 1'b1 && n < 9000) begin
            @(negedge mclk_i);
            n++;
        end
        check("ready_busy_n", 16'h0001, 16'(rb_n));
        repeat (4) @(negedge mclk_i);
        rd_chk(26'h0000123, 16'hFFFF);
        rd_chk(26'h0000300, 16'h1234);
    endtask

    task automatic s_reset();
        op_chk(fas_pkg::OP_PROG, 26'h0000500, 16'h0000, 1'b0);
        op_chk(fas_pkg::OP_RESET, 26'h0000000, 16'h0000, 1'b0);
        check("reset length", 16'h0001, 16'(r_lat >= fas_pkg::RP_CYC + 20));
        check("busy_o", 16'h0000, 16'(busy_o));
        rd_chk(26'h0000500, 16'hFFFF);
        op_chk(fas_pkg::OP_PROG, 26'h0000500, 16'h0000, 1'b0);
        wait_idle();
        rd_chk(26'h0000500, 16'h0000);
    endtask

    task automatic s_overlay();
        op_chk(fas_pkg::OP_WRITE, 26'h0000555, 16'h00AA, 1'b0);
        op_chk(fas_pkg::OP_WRITE, 26'h00002AA, 16'h0055, 1'b0);
        op_chk(fas_pkg::OP_WRITE, 26'h0000555, 16'h0040, 1'b0);
        op_chk(fas_pkg::OP_PROG_OVL, 26'h0000005, 16'h1234, 1'b0);
        wait_idle();
        rd_chk(26'h0000005, 16'h1234);
        op_chk(fas_pkg::OP_WRITE, 26'h0000000, 16'h0090, 1'b0);
        rd_chk(26'h0000005, 16'hFFFF);
    endtask

    initial begin
        sys_rst_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_op_i = fas_pkg::OP_READ;
        cmd_addr_i = 26'h0000000;
        cmd_data_i = 16'h0000;
        repeat (8) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        s_program();
        s_page();
        s_suspend();
        s_erase();
        s_reset();
        s_overlay();
        finish_test();
    end

    initial begin
        #120000;
        mismatches++;
        finish_test();
    end
endmodule
